//--- design/wdt_params.svh
// Constants of the windowed watchdog: register indices, field positions, bus transfer codes, timing.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
//
// How it works
// - When enabled, counting runs continuously and expiry without restart resets the system.
// - Each restart starts a fresh period; normal mode accepts restarts at any time.
// - timeout_select bits 5:2 choose 8 to 8192 oscillator cycles, doubling per code.
// - Reserved timeout_select codes 1011 to 1111 never time out.
// - In window mode a restart inside the closed window resets the system at once; here the reset waits for the next oscillator tick.
// - Open window follows the closed one; total period is closed plus open.
// - Counting uses the 1kHz low-power oscillator tick, independent of processor activity.
// - A watchdog_control write takes effect only with change_unlock written as one.
// - With the lock fuse programmed, watchdog_control is entirely read-only.
// - When locked, closed_window_select is read-only; window enable and its unlock stay writable.
// - A watchdog-caused system reset keeps the configuration held before it.
// - Fuses load timeout_select and enable at power-on; change_unlock zero; bits 7:6 read zero.
// - Enable at bit 1 starts and stops the watchdog, subject to unlock and protection.
// - window_control: closed_window_select 5:2, window enable 1, window_change_unlock 0.
// - closed_window_select uses the same encoding; reserved codes give no closed window.
// - Writes while enabled set sync_pending until the oscillator domain takes the value.
// - Window mode is active only with its enable set; changes need window_change_unlock.
// - window_change_unlock obeys timed-write protection but ignores the lock fuse.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_IDX_CONTROL 2'h0
`define WDT_IDX_WINDOW 2'h1
`define WDT_IDX_STATUS 2'h2
`define WDT_ADDR_LSB 2
`define WDT_SEL_MSB 5
`define WDT_SEL_LSB 2
`define WDT_ENABLE_BIT 1
`define WDT_UNLOCK_BIT 0
`define WDT_SYNC_BIT 0
`define WDT_LAST_CODE 4'ha
`define WDT_BASE_CYCLES 14'h0008
`define WDT_CNT_W 14
`define WDT_HTRANS_NONSEQ 2'h2
`define WDT_HTRANS_SEQ 2'h3

`endif

//--- design/wdt_pkg.sv
// Types shared by the windowed watchdog.
// Constants live in wdt_params.svh.
package wdt_pkg;

    typedef struct packed {
        logic [3:0] timeout_select;
        logic enable;
        logic change_unlock;
    } control_s;

    typedef struct packed {
        logic [3:0] closed_window_select;
        logic window_enable;
        logic window_change_unlock;
    } window_s;

    // Gray along idle -> closed -> open
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_closed = 2'b01,
        st_open = 2'b11
    } phase_e;

endpackage : wdt_pkg

//--- design/windowed_watchdog_timer.sv
// Windowed watchdog timer with AHB-Lite register access.
// Assumes low_power_tick is the 1kHz oscillator output sampled on clk, and that
// config_protect_open comes from the processor's timed-write protection logic.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "wdt_params.svh"

module windowed_watchdog_timer
    import wdt_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic low_power_tick,
    input wire logic restart_instruction,
    input wire logic config_protect_open,
    input wire logic lock_fuse,
    input wire logic [3:0] timeout_fuse,
    input wire logic enable_fuse,
    input wire logic [3:0] window_timeout_fuse,
    input wire logic window_enable_fuse,
    output logic system_reset
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Zero means no timeout for this code
    function automatic logic [`WDT_CNT_W-1:0] period_cycles(input logic [3:0] code);
        if (code > `WDT_LAST_CODE) begin
            period_cycles = '0;
        end else begin
            period_cycles = `WDT_BASE_CYCLES << code;
        end
    endfunction : period_cycles

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend;
    logic [1:0] wr_idx;
    logic addr_ok;
    logic [1:0] req_idx;
    logic take;
    logic fuses_loaded;
    control_s ctrl;
    window_s win;
    logic sync_pending;
    logic wr_ctrl;
    logic wr_win;
    logic [31:0] next_rdata;

    assign take = hsel && hready && (htrans == `WDT_HTRANS_NONSEQ || htrans == `WDT_HTRANS_SEQ);
    assign req_idx = haddr[`WDT_ADDR_LSB+1:`WDT_ADDR_LSB];
    assign addr_ok = (haddr[31:`WDT_ADDR_LSB+2] == '0);
    // Writes outside the protected sequence are dropped
    assign wr_ctrl = wr_pend && wr_idx == `WDT_IDX_CONTROL && config_protect_open;
    assign wr_win = wr_pend && wr_idx == `WDT_IDX_WINDOW && config_protect_open;

    always_comb begin
        next_rdata = '0;
        if (addr_ok) begin
            unique case (req_idx)
                `WDT_IDX_CONTROL: next_rdata[5:0] = ctrl;
                `WDT_IDX_WINDOW: next_rdata[5:0] = win;
                `WDT_IDX_STATUS: next_rdata[`WDT_SYNC_BIT] = sync_pending;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend <= 1'b0;
            wr_idx <= 2'h0;
            hrdata <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= take && hwrite && addr_ok;
            wr_idx <= req_idx;
            if (take && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Fuse levels are caught after reset release, never by the async reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fuses_loaded <= 1'b0;
            ctrl <= '0;
            win <= '0;
        end else if (!fuses_loaded) begin
            fuses_loaded <= 1'b1;
            ctrl <= '{timeout_select: timeout_fuse, enable: enable_fuse, change_unlock: 1'b0};
            win <= '{closed_window_select: window_timeout_fuse, window_enable: window_enable_fuse,
                     window_change_unlock: 1'b0};
        end else begin
            if (wr_ctrl && !lock_fuse) begin
                ctrl.change_unlock <= hwdata[`WDT_UNLOCK_BIT];
                if (hwdata[`WDT_UNLOCK_BIT]) begin
                    ctrl.timeout_select <= hwdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
                    ctrl.enable <= hwdata[`WDT_ENABLE_BIT];
                end
            end
            if (wr_win) begin
                win.window_change_unlock <= hwdata[`WDT_UNLOCK_BIT];
                if (hwdata[`WDT_UNLOCK_BIT]) begin
                    win.window_enable <= hwdata[`WDT_ENABLE_BIT];
                    if (!lock_fuse) begin
                        win.closed_window_select <= hwdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator tick and crossing into the counting logic
    // ------------------------------------------------------------
    logic tick_q;
    logic tick;
    logic restart_pend;
    control_s act_ctrl;
    window_s act_win;

    assign tick = low_power_tick && !tick_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= low_power_tick;
        end
    end

    // Restart waits for the tick; a new request in the same cycle is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            restart_pend <= 1'b0;
        end else if (restart_instruction) begin
            restart_pend <= 1'b1;
        end else if (tick) begin
            restart_pend <= 1'b0;
        end
    end

    // Busy only when the counting side is live; a write in the tick cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_pending <= 1'b0;
        end else if ((wr_ctrl || wr_win) && act_ctrl.enable) begin
            sync_pending <= 1'b1;
        end else if (tick) begin
            sync_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_ctrl <= '0;
            act_win <= '0;
        end else if (tick || !act_ctrl.enable) begin
            act_ctrl <= ctrl;
            act_win <= win;
        end
    end

    // ------------------------------------------------------------
    // Counting and reset generation
    // ------------------------------------------------------------
    phase_e phase;
    logic [`WDT_CNT_W-1:0] count;
    logic [`WDT_CNT_W-1:0] open_len;
    logic [`WDT_CNT_W-1:0] closed_len;
    logic [`WDT_CNT_W-1:0] count_inc;
    logic windowed;
    phase_e start_phase;
    logic early_restart;
    logic expired;
    logic closed_done;

    assign open_len = period_cycles(act_ctrl.timeout_select);
    assign closed_len = period_cycles(act_win.closed_window_select);
    assign count_inc = count + `WDT_CNT_W'(1);
    // Reserved closed code leaves only the open window
    assign windowed = act_win.window_enable && closed_len != '0;
    assign start_phase = windowed ? st_closed : st_open;
    assign early_restart = restart_pend && phase == st_closed && windowed;
    assign expired = phase == st_open && open_len != '0 && count_inc >= open_len;
    assign closed_done = phase == st_closed && count_inc >= closed_len;

    // Config registers are untouched by the pulse, so settings survive it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= st_idle;
            count <= '0;
            system_reset <= 1'b0;
        end else begin
            system_reset <= 1'b0;
            if (tick) begin
                if (!act_ctrl.enable) begin
                    phase <= st_idle;
                    count <= '0;
                end else begin
                    unique case (phase)
                        st_idle: begin
                            phase <= start_phase;
                            count <= '0;
                        end
                        st_closed, st_open: begin
                            if (restart_pend) begin
                                system_reset <= early_restart;
                                phase <= start_phase;
                                count <= '0;
                            end else if (expired) begin
                                system_reset <= 1'b1;
                                phase <= start_phase;
                                count <= '0;
                            end else if (closed_done) begin
                                phase <= st_open;
                                count <= '0;
                            end else begin
                                count <= count_inc;
                            end
                        end
                        default: begin
                            phase <= st_idle;
                            count <= '0;
                        end
                    endcase
                end
            end
        end
    end

endmodule : windowed_watchdog_timer

//--- test/wdt_monitor.sv
// Port checker for the windowed watchdog.
// Assumes a zero-wait AHB-Lite slave and a clk-sampled oscillator tick.
`timescale 1ns/1ps
module wdt_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic low_power_tick,
    input wire logic system_reset
);
    logic tick_q;
    logic [2:0] since_tick;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Saturating age of the last tick; bounds where a reset pulse may fall
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 1'h0;
            since_tick <= 3'h7;
        end else begin
            tick_q <= low_power_tick;
            since_tick <= (low_power_tick && !tick_q) ? 3'h0 : since_tick + 3'(since_tick != 3'h7);
        end
    end
    sequence read_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    pulse_single_a: assert property (system_reset |=> !system_reset) else $error("long reset pulse");
    pulse_tick_a: assert property (system_reset |-> since_tick <= 3'h5) else $error("pulse off tick");
    upper_zero_a: assert property (read_taken |=> hrdata[31:6] == 26'h0) else $error("upper bits set");
    unmapped_zero_a: assert property (read_taken ##0 haddr >= 32'hc |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    status_bits_a: assert property (read_taken ##0 haddr == 32'h8 |=> hrdata[31:1] == 31'h0)
        else $error("status bits set");
    data_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
    ready_high_a: assert property ($past(arst_n) |-> hreadyout) else $error("wait state");
    okay_resp_a: assert property (hresp == 1'h0) else $error("error response");
endmodule : wdt_monitor

bind windowed_watchdog_timer wdt_monitor wdt_monitor_inst (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .low_power_tick, .system_reset);

//--- test/cpu_core_model.sv
// CPU side: opens the timed-write protection and issues restarts on request.
// Assumes requests come from the bench one cycle wide.
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic open_req,
    input wire logic kick_req,
    output logic config_protect_open,
    output logic restart_instruction
);
    logic [2:0] open_left;
    // Short window so late writes are refused as on real parts
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            open_left <= 3'h0;
            restart_instruction <= 1'h0;
        end else begin
            open_left <= open_req ? 3'h6 : open_left - 3'(open_left != 3'h0);
            restart_instruction <= kick_req;
        end
    end
    assign config_protect_open = open_left != 3'h0;
endmodule : cpu_core_model

//--- test/windowed_watchdog_timer_bench.sv
// Bench for the windowed watchdog: AHB-Lite tasks, tick source, scenarios.
// Assumes cpu_core_model and the bound wdt_monitor.
`timescale 1ns/1ps
`include "wdt_params.svh"
module windowed_watchdog_timer_bench;
    logic clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, low_power_tick = 1'h0, tick_q = 1'h0;
    logic lock_fuse = 1'h0, en_fuse = 1'h0, wen_fuse = 1'h0, open_req = 1'h0, kick_req = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [3:0] tfuse = 4'h3, wfuse = 4'h2, c;
    logic hready, hreadyout, hresp, system_reset, restart_instruction, config_protect_open;
    int n_errors = 0, cmp_count = 0, ticks = 0, pulses = 0, cycles = 0, g, p0;
    assign hready = hreadyout;
    windowed_watchdog_timer windowed_watchdog_timer_inst (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .low_power_tick, .restart_instruction,
        .config_protect_open, .lock_fuse, .timeout_fuse(tfuse), .enable_fuse(en_fuse),
        .window_timeout_fuse(wfuse), .window_enable_fuse(wen_fuse), .system_reset);
    cpu_core_model cpu_core_model_inst (.clk, .arst_n, .open_req, .kick_req, .config_protect_open,
        .restart_instruction);
    always #10 clk = ~clk;
    // Oscillator sped up to one tick per 8 clocks
    always begin
        repeat (4) @(posedge clk);
        low_power_tick <= ~low_power_tick;
    end
    always @(posedge clk) begin
        tick_q <= low_power_tick;
        ticks <= ticks + int'(low_power_tick && !tick_q);
        pulses <= pulses + int'(system_reset === 1'h1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    function automatic logic [31:0] regv(input logic [3:0] s, input logic b1, input logic b0);
        return {26'h0, s, b1, b0};
    endfunction : regv
    function automatic int per(input logic [3:0] s);
        return (s > 4'ha) ? -1 : 8 << s;
    endfunction : per
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= `WDT_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        open_req <= p;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        open_req <= 1'h0;
        do @(posedge clk); while (hready !== 1'h1);
        q = hrdata;
    endtask : bus
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(1'h0, 1'h0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk
    task automatic kick();
        @(posedge clk);
        kick_req <= 1'h1;
        @(posedge clk);
        kick_req <= 1'h0;
    endtask : kick
    // Ticks between two reset pulses, -1 if fewer than two
    task automatic gap(input int lim, output int r);
        int a;
        a = -1;
        r = -1;
        repeat (lim) begin
            @(posedge clk);
            if (system_reset === 1'h1) begin
                if (a >= 0) break;
                a = ticks;
            end
        end
        if (system_reset === 1'h1 && a >= 0 && a != ticks) r = ticks - a;
    endtask : gap
    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(32'hb960));
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        rd_chk(32'h0, regv(4'h3, 1'h0, 1'h0));
        rd_chk(32'h4, regv(4'h2, 1'h0, 1'h0));
        rd_chk(32'hc, 32'h0);
        bus(1'h1, 1'h0, 32'h0, 32'h3);
        bus(1'h1, 1'h1, 32'h0, 32'h2);
        rd_chk(32'h0, regv(4'h3, 1'h0, 1'h0));
        bus(1'h1, 1'h1, 32'h0, {26'($urandom), 6'h3});
        rd_chk(32'h0, 32'h3);
        for (int i = 0; i < 4; i++) begin
            c = (i == 3) ? 4'hb + 4'($urandom % 5) : 4'($urandom % 3);
            bus(1'h1, 1'h1, 32'h0, regv(c, 1'h1, 1'h1));
            kick();
            gap(1100, g);
            chk(g, per(c));
            rd_chk(32'h0, regv(c, 1'h1, 1'h1));
        end
        rd_chk(32'h8, 32'h0);
        // Line the write up just behind a tick so the flag still stands at the read
        @(posedge low_power_tick);
        bus(1'h1, 1'h1, 32'h0, 32'h3);
        rd_chk(32'h8, 32'h1);
        p0 = pulses;
        repeat (10) begin
            kick();
            repeat (30) @(posedge clk);
        end
        chk(pulses - p0, 0);
        bus(1'h1, 1'h1, 32'h4, 32'h3);
        kick();
        gap(900, g);
        chk(g, 16);
        kick();
        p0 = pulses;
        repeat (30) @(posedge clk);
        chk(pulses - p0, 1);
        lock_fuse <= 1'h1;
        bus(1'h1, 1'h1, 32'h0, 32'h15);
        rd_chk(32'h0, 32'h3);
        bus(1'h1, 1'h1, 32'h4, 32'h1d);
        rd_chk(32'h4, 32'h1);
        arst_n <= 1'h0;
        tfuse <= 4'($urandom % 11);
        wfuse <= 4'($urandom);
        en_fuse <= 1'($urandom);
        wen_fuse <= 1'($urandom);
        lock_fuse <= 1'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        rd_chk(32'h0, regv(tfuse, en_fuse, 1'h0));
        rd_chk(32'h4, regv(wfuse, wen_fuse, 1'h0));
        complete_run();
    end
endmodule : windowed_watchdog_timer_bench
